// file: verilog/scb_pkg.sv
// Shared constants for the two-wire bus control and bus status block
package scb_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   // Register byte addresses
   localparam logic [15:0] CTRL_ADDR = 16'hffa6;
   localparam logic [15:0] FLAG_ADDR = 16'hffa7;
   localparam logic [15:0] STAT_ADDR = 16'hffa8;
   localparam logic [15:0] IRQ_ST_ADDR = 16'hffa9;
   localparam logic [15:0] IRQ_MASK_ADDR = 16'hffaa;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Control register bit positions
   localparam int unsigned CTRL_WAIT_CANCEL = 7;
   localparam int unsigned CTRL_OP_ENABLE = 6;
   localparam int unsigned CTRL_EXIT_COMM = 5;
   localparam int unsigned CTRL_STOP_IRQ_EN = 4;
   localparam int unsigned CTRL_WAIT_TIMING = 3;
   localparam int unsigned CTRL_ACK_EN = 2;
   localparam int unsigned CTRL_START_REQ = 1;
   localparam int unsigned CTRL_STOP_REQ = 0;
   // Flag register bit positions
   localparam int unsigned FLAG_START_FAIL = 7;
   localparam int unsigned FLAG_BUS_BUSY = 6;
   localparam int unsigned FLAG_INIT_STATUS = 1;
   localparam int unsigned FLAG_RSV_DISABLE = 0;
   // Transfer status register bit positions
   localparam int unsigned ST_MASTER = 7;
   localparam int unsigned ST_EXT_CODE = 6;
   localparam int unsigned ST_ADDR_MATCH = 5;
   localparam int unsigned ST_TX_DIR = 4;
   localparam int unsigned ST_ACK_DET = 3;
   localparam int unsigned ST_START_DET = 2;
   localparam int unsigned ST_STOP_DET = 1;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // Interrupt status bit positions
   localparam int unsigned IRQ_STOP = 0;
   localparam int unsigned IRQ_START = 1;
   localparam int unsigned IRQ_START_FAIL = 2;
   localparam int unsigned IRQ_W = 3;
   // Bus timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned START_HOLD_NS = 4000;
   localparam int unsigned STOP_SETUP_NS = 4000;
   localparam int unsigned START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STOP_SETUP_CYC = (STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 10;
   typedef enum logic [2:0] {
      SCB_IDLE,
      SCB_START,
      SCB_WAIT,
      SCB_XFER,
      SCB_STOP_LOW,
      SCB_STOP_SETUP
   } scb_state_t;
endpackage : scb_pkg

// file: verilog/scb_ctrl.sv
// Two-wire bus control register, bus status detector and start/stop generator
//
// Notes on behaviour
// [R1] Bus busy tracked from start and stop conditions
// [R2] Initial busy state taken from initial-status bit
// [R3] Flag register: fail 7, busy 6, init 1, rsv 0
// [R4] Control register at ffa6, reset value zero
// [R5] Control bits: cancel, enable, exit, spie, wtim, acke, start, stop
// [R6] Software changes config bits only disabled or waiting
// [R7] Config bits accepted with enable rising write
// [R8] Disabled: serial logic stopped, status held reset
// [R9] Software enables only while both lines high
// [R10] Exit write abandons transfer, bit self-clears
// [R11] Exit releases clock and data drivers
// [R12] Exit clears request and transfer status flags
// [R13] Standby until stop-restart or start-address match
// [R14] Wait cancel releases clock, bit self-clears
// [R15] Ninth-clock transmit cancel clears direction, releases data
// [R16] Busy reserved start request ignored, fail flag set
// [R17] Stop request generates stop condition
// [R18] Enable with clock high, data low registers start
// [R19] Writing zero to exit or cancel does nothing
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module scb_ctrl #(
   parameter int unsigned START_HOLD = scb_pkg::START_HOLD_CYC,
   parameter int unsigned STOP_SETUP = scb_pkg::STOP_SETUP_CYC
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_match_i,
   input wire logic ext_code_i,
   input wire logic ack_seen_i,
   input wire logic byte_done_i,
   output logic wait_timing_o,
   output logic ack_enable_o,
   output logic irq_o
);
   initial
   begin
      if (START_HOLD < 1 || START_HOLD >= (1 << scb_pkg::TIMER_W))
         $error("START_HOLD out of range");
      if (STOP_SETUP < 1 || STOP_SETUP >= (1 << scb_pkg::TIMER_W))
         $error("STOP_SETUP out of range");
   end

   logic [7:0] ctrl_q;
   logic [7:0] flag_q;
   logic [7:0] stat_q;
   logic [scb_pkg::IRQ_W-1:0] irq_st_q;
   logic [scb_pkg::IRQ_W-1:0] irq_mask_q;
   logic [7:0] rdata_q;
   logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
   logic scl_prev_q, sda_prev_q;
   logic standby_q;
   logic stop_seen_q;
   logic scl_hold_q, sda_low_q;
   logic [scb_pkg::TIMER_W-1:0] timer_q;
   scb_pkg::scb_state_t state_q;

   logic wr_ctrl, wr_flag, wr_irq_st, wr_irq_mask;
   logic en, en_rise, exit_req, cancel_req;
   logic start_cond, stop_cond, forced_start;
   logic start_fail, start_go, in_wait, ninth_tx_cancel;
   logic timer_done;

   assign wr_ctrl = reg_we_i && reg_addr_i == scb_pkg::CTRL_ADDR;
   assign wr_flag = reg_we_i && reg_addr_i == scb_pkg::FLAG_ADDR;
   assign wr_irq_st = reg_we_i && reg_addr_i == scb_pkg::IRQ_ST_ADDR;
   assign wr_irq_mask = reg_we_i && reg_addr_i == scb_pkg::IRQ_MASK_ADDR;
   assign en = ctrl_q[scb_pkg::CTRL_OP_ENABLE];
   assign en_rise = wr_ctrl && !en && reg_wdata_i[scb_pkg::CTRL_OP_ENABLE];
   // A zero written to these bits is simply not an event
   assign exit_req = wr_ctrl && en && reg_wdata_i[scb_pkg::CTRL_EXIT_COMM]; // [R19]
   assign cancel_req = wr_ctrl && en && reg_wdata_i[scb_pkg::CTRL_WAIT_CANCEL]; // [R19]
   assign in_wait = state_q == scb_pkg::SCB_WAIT;
   assign timer_done = timer_q == '0;

   // Pin synchronisers; the second stage and its one-cycle delayed copy are looked at
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         scl_prev_q <= scl_s_q;
         sda_prev_q <= sda_s_q;
      end
   end

   // Data edges while the clock stays high mark start and stop
   assign start_cond = en && scl_s_q && scl_prev_q && sda_prev_q && !sda_s_q; // [R1]
   assign stop_cond = en && scl_s_q && scl_prev_q && !sda_prev_q && sda_s_q; // [R1]
   // Line already in start shape when the block wakes up
   assign forced_start = en_rise && scl_s_q && !sda_s_q; // [R18]

   assign start_fail = wr_ctrl && en && reg_wdata_i[scb_pkg::CTRL_START_REQ]
      && flag_q[scb_pkg::FLAG_RSV_DISABLE] && flag_q[scb_pkg::FLAG_BUS_BUSY]; // [R16]
   // Start is launched only onto a free bus; a busy request waits as reserved unless reservation is disabled
   assign start_go = en && !exit_req && state_q == scb_pkg::SCB_IDLE
      && ctrl_q[scb_pkg::CTRL_START_REQ] && !flag_q[scb_pkg::FLAG_BUS_BUSY]
      && (!standby_q || stop_seen_q); // [R13]
   assign ninth_tx_cancel = cancel_req && in_wait
      && ctrl_q[scb_pkg::CTRL_WAIT_TIMING] && stat_q[scb_pkg::ST_TX_DIR]; // [R15]

   // Control register
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         ctrl_q <= scb_pkg::CTRL_RESET; // [R4]
      else if (wr_ctrl)
      begin
         ctrl_q[scb_pkg::CTRL_OP_ENABLE] <= reg_wdata_i[scb_pkg::CTRL_OP_ENABLE]; // [R5]
         // Timing bits only move when the engine cannot be using them
         if (!en || en_rise || in_wait) // [R7]
         begin
            ctrl_q[scb_pkg::CTRL_STOP_IRQ_EN] <= reg_wdata_i[scb_pkg::CTRL_STOP_IRQ_EN];
            ctrl_q[scb_pkg::CTRL_WAIT_TIMING] <= reg_wdata_i[scb_pkg::CTRL_WAIT_TIMING];
            ctrl_q[scb_pkg::CTRL_ACK_EN] <= reg_wdata_i[scb_pkg::CTRL_ACK_EN];
         end
         if (exit_req || !reg_wdata_i[scb_pkg::CTRL_OP_ENABLE])
         begin
            ctrl_q[scb_pkg::CTRL_START_REQ] <= 1'b0; // [R12]
            ctrl_q[scb_pkg::CTRL_STOP_REQ] <= 1'b0; // [R12]
         end
         else
         begin
            // A write beside a launch must not leave the old request armed
            if (reg_wdata_i[scb_pkg::CTRL_START_REQ] && !start_fail)
               ctrl_q[scb_pkg::CTRL_START_REQ] <= 1'b1;
            else if (start_go)
               ctrl_q[scb_pkg::CTRL_START_REQ] <= 1'b0;
            if (reg_wdata_i[scb_pkg::CTRL_STOP_REQ])
               ctrl_q[scb_pkg::CTRL_STOP_REQ] <= 1'b1; // [R17]
            else if (state_q == scb_pkg::SCB_STOP_SETUP && timer_done)
               ctrl_q[scb_pkg::CTRL_STOP_REQ] <= 1'b0;
         end
         // Both are one-shot commands; they read back as zero
         ctrl_q[scb_pkg::CTRL_EXIT_COMM] <= 1'b0; // [R10]
         ctrl_q[scb_pkg::CTRL_WAIT_CANCEL] <= 1'b0; // [R14]
      end
      else
      begin
         if (start_go)
            ctrl_q[scb_pkg::CTRL_START_REQ] <= 1'b0;
         if (state_q == scb_pkg::SCB_STOP_SETUP && timer_done)
            ctrl_q[scb_pkg::CTRL_STOP_REQ] <= 1'b0;
      end
   end

   assign wait_timing_o = en && ctrl_q[scb_pkg::CTRL_WAIT_TIMING];
   assign ack_enable_o = en && ctrl_q[scb_pkg::CTRL_ACK_EN];

   // Flag register: busy follows the bus, seeded from the initial-status bit
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         flag_q <= 8'h00;
      else
      begin
         if (wr_flag)
         begin
            flag_q[scb_pkg::FLAG_INIT_STATUS] <= reg_wdata_i[scb_pkg::FLAG_INIT_STATUS]; // [R3]
            flag_q[scb_pkg::FLAG_RSV_DISABLE] <= reg_wdata_i[scb_pkg::FLAG_RSV_DISABLE]; // [R3]
         end
         if (!en && !en_rise)
         begin
            flag_q[scb_pkg::FLAG_START_FAIL] <= 1'b0; // [R8]
            flag_q[scb_pkg::FLAG_BUS_BUSY] <= 1'b0; // [R8]
         end
         else if (en_rise)
            // A set initial-status bit lets a master start before any stop
            flag_q[scb_pkg::FLAG_BUS_BUSY] <= forced_start
               || !flag_q[scb_pkg::FLAG_INIT_STATUS]; // [R2]
         else
         begin
            if (start_cond || start_go)
               flag_q[scb_pkg::FLAG_BUS_BUSY] <= 1'b1; // [R1]
            else if (stop_cond)
               flag_q[scb_pkg::FLAG_BUS_BUSY] <= 1'b0; // [R1]
            // Set wins over a new start request that would clear it
            if (start_fail)
               flag_q[scb_pkg::FLAG_START_FAIL] <= 1'b1; // [R16]
            else if (start_go)
               flag_q[scb_pkg::FLAG_START_FAIL] <= 1'b0;
         end
      end
   end

   // Standby after exit lasts until a legal entry condition
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         standby_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end
      else if (!en)
      begin
         standby_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end
      else if (exit_req)
      begin
         standby_q <= 1'b1; // [R10]
         stop_seen_q <= 1'b0;
      end
      else if (standby_q)
      begin
         if (stop_cond)
            stop_seen_q <= 1'b1;
         if (start_go || addr_match_i || ext_code_i)
            standby_q <= 1'b0; // [R13]
      end
   end

   // Transfer status register
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         stat_q <= scb_pkg::STAT_RESET;
      else if (!en && !en_rise)
         stat_q <= scb_pkg::STAT_RESET; // [R8]
      else if (exit_req)
      begin
         stat_q[scb_pkg::ST_MASTER] <= 1'b0; // [R12]
         stat_q[scb_pkg::ST_EXT_CODE] <= 1'b0; // [R12]
         stat_q[scb_pkg::ST_ADDR_MATCH] <= 1'b0; // [R12]
         stat_q[scb_pkg::ST_TX_DIR] <= 1'b0; // [R12]
         stat_q[scb_pkg::ST_ACK_DET] <= 1'b0; // [R12]
         stat_q[scb_pkg::ST_START_DET] <= 1'b0; // [R12]
      end
      else
      begin
         if (forced_start || start_cond)
            stat_q[scb_pkg::ST_START_DET] <= 1'b1; // [R18]
         else if (byte_done_i)
            stat_q[scb_pkg::ST_START_DET] <= 1'b0;
         if (stop_cond)
         begin
            stat_q[scb_pkg::ST_STOP_DET] <= 1'b1;
            stat_q[scb_pkg::ST_MASTER] <= 1'b0;
            stat_q[scb_pkg::ST_TX_DIR] <= 1'b0;
         end
         else if (start_cond)
            stat_q[scb_pkg::ST_STOP_DET] <= 1'b0;
         if (start_go)
         begin
            stat_q[scb_pkg::ST_MASTER] <= 1'b1;
            stat_q[scb_pkg::ST_TX_DIR] <= 1'b1;
         end
         else if (ninth_tx_cancel)
            stat_q[scb_pkg::ST_TX_DIR] <= 1'b0; // [R15]
         if (!standby_q || start_cond)
         begin
            if (addr_match_i)
               stat_q[scb_pkg::ST_ADDR_MATCH] <= 1'b1;
            if (ext_code_i)
               stat_q[scb_pkg::ST_EXT_CODE] <= 1'b1;
         end
         if (ack_seen_i)
            stat_q[scb_pkg::ST_ACK_DET] <= 1'b1;
      end
   end

   // Start and stop generator with clock wait
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= scb_pkg::SCB_IDLE;
         timer_q <= '0;
         scl_hold_q <= 1'b0;
         sda_low_q <= 1'b0;
      end
      else if (!en || exit_req)
      begin
         state_q <= scb_pkg::SCB_IDLE; // [R8]
         timer_q <= '0;
         scl_hold_q <= 1'b0; // [R11]
         sda_low_q <= 1'b0; // [R11]
      end
      else
      begin
         if (!timer_done)
            timer_q <= timer_q - 1'b1;
         unique case (state_q)
            scb_pkg::SCB_IDLE:
               if (start_go)
               begin
                  sda_low_q <= 1'b1;
                  timer_q <= scb_pkg::TIMER_W'(START_HOLD);
                  state_q <= scb_pkg::SCB_START;
               end
            scb_pkg::SCB_START:
               if (timer_done)
               begin
                  // Clock held low: the byte engine takes over after the wait
                  scl_hold_q <= 1'b1;
                  state_q <= scb_pkg::SCB_WAIT;
               end
            scb_pkg::SCB_WAIT:
               if (cancel_req)
               begin
                  scl_hold_q <= 1'b0; // [R14]
                  if (ninth_tx_cancel)
                     sda_low_q <= 1'b0; // [R15]
                  state_q <= scb_pkg::SCB_XFER;
               end
               else if (ctrl_q[scb_pkg::CTRL_STOP_REQ])
               begin
                  sda_low_q <= 1'b1;
                  scl_hold_q <= 1'b0;
                  state_q <= scb_pkg::SCB_STOP_LOW;
               end
            scb_pkg::SCB_XFER:
               if (byte_done_i)
               begin
                  scl_hold_q <= 1'b1;
                  state_q <= scb_pkg::SCB_WAIT;
               end
            scb_pkg::SCB_STOP_LOW:
               // Data stays low until the clock is seen high again, then through the stop setup time
               if (scl_s_q)
               begin
                  timer_q <= scb_pkg::TIMER_W'(STOP_SETUP);
                  state_q <= scb_pkg::SCB_STOP_SETUP;
               end
            scb_pkg::SCB_STOP_SETUP:
               if (timer_done)
               begin
                  sda_low_q <= 1'b0; // [R17]
                  state_q <= scb_pkg::SCB_IDLE;
               end
         endcase
      end
   end

   // Open-drain pins: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_hold_q;
   assign sda_oe_o = sda_low_q;

   // Interrupt status, write one to clear; new events win
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         irq_st_q <= '0;
         irq_mask_q <= '0;
      end
      else
      begin
         if (wr_irq_mask)
            irq_mask_q <= reg_wdata_i[scb_pkg::IRQ_W-1:0];
         irq_st_q <= (irq_st_q & ~(wr_irq_st ? reg_wdata_i[scb_pkg::IRQ_W-1:0] : '0))
            | {start_fail, start_cond || forced_start,
               stop_cond && ctrl_q[scb_pkg::CTRL_STOP_IRQ_EN]};
      end
   end

   assign irq_o = |(irq_st_q & irq_mask_q);

   // Read port: data one cycle after the strobe, zero elsewhere
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         rdata_q <= 8'h00;
      else if (reg_re_i)
      begin
         unique case (reg_addr_i)
            scb_pkg::CTRL_ADDR: rdata_q <= ctrl_q;
            scb_pkg::FLAG_ADDR: rdata_q <= flag_q;
            scb_pkg::STAT_ADDR: rdata_q <= stat_q;
            scb_pkg::IRQ_ST_ADDR: rdata_q <= {{(8 - scb_pkg::IRQ_W){1'b0}}, irq_st_q};
            scb_pkg::IRQ_MASK_ADDR: rdata_q <= {{(8 - scb_pkg::IRQ_W){1'b0}}, irq_mask_q};
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   assign reg_rdata_o = rdata_q;
endmodule : scb_ctrl
`default_nettype wire

// file: test/scb_bus_model.sv
// Far-side bus device: pull-ups plus a second master
`timescale 1ns/10ps
`default_nettype none
module scb_bus_model (
   input wire logic scl_oe_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic scl_pull = 1'b0;
   logic sda_pull = 1'b0;
   // Pull-ups: a released line reads high, never a stale value
   assign scl_o = ~(scl_oe_i | scl_pull);
   assign sda_o = ~(sda_oe_i | sda_pull);
   // Link half period 80 ns; offset keeps edges off the core clock
   task automatic start_cond();
      #3;
      sda_pull = 1'b1;
      #80;
      scl_pull = 1'b1;
      #80;
   endtask : start_cond
   task automatic stop_cond();
      #3;
      sda_pull = 1'b1;
      #80;
      scl_pull = 1'b0;
      #80;
      sda_pull = 1'b0;
      #80;
   endtask : stop_cond
   // Stuck data line with clock idle high
   task automatic hold_data_low(input logic low);
      #3;
      sda_pull = low;
   endtask : hold_data_low
endmodule : scb_bus_model
`default_nettype wire

// file: test/scb_ctrl_chk.sv
// Port-level assertions for the bus control block
`timescale 1ns/10ps
`default_nettype none
module scb_ctrl_chk (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o,
   input wire logic wait_timing_o,
   input wire logic ack_enable_o
);
   logic en_q;
   logic en_prev_q;
   logic [1:0] cfg_q;
   logic ctrl_wr;
   assign ctrl_wr = reg_we_i && (reg_addr_i == scb_pkg::CTRL_ADDR);
   // Shadow of the enable bit, as software last wrote it
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         en_q <= 1'b0;
         en_prev_q <= 1'b0;
         cfg_q <= 2'h0;
      end
      else
      begin
         if (ctrl_wr)
            en_q <= reg_wdata_i[6];
         en_prev_q <= en_q;
         cfg_q <= reg_wdata_i[3:2];
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   rdata_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (reg_re_i && (reg_addr_i < scb_pkg::CTRL_ADDR ||
      reg_addr_i > scb_pkg::IRQ_MASK_ADDR) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   selfclr_read_a: assert property (reg_re_i && reg_addr_i == scb_pkg::CTRL_ADDR
      |=> (reg_rdata_o & 8'ha0) == 8'h00)
      else $error("exit or cancel bit reads one");
   exit_release_a: assert property (ctrl_wr && en_q && reg_wdata_i[5]
      |-> ##2 !scl_oe_o && !sda_oe_o)
      else $error("line driven after exit");
   disabled_quiet_a: assert property (!en_q && !en_prev_q
      |-> !(scl_oe_o || sda_oe_o || wait_timing_o || ack_enable_o))
      else $error("activity while disabled");
   enable_cfg_a: assert property (ctrl_wr && reg_wdata_i[6] && !en_q
      |=> {wait_timing_o, ack_enable_o} == cfg_q)
      else $error("config not taken with enable");
   cancel_release_a: assert property (ctrl_wr && en_q && reg_wdata_i[7] && reg_wdata_i[6]
      && scl_oe_o |=> !scl_oe_o)
      else $error("clock still held after cancel");
   stop_gen_a: assert property (ctrl_wr && en_q && reg_wdata_i[6] && reg_wdata_i[0]
      && !reg_wdata_i[5] && !reg_wdata_i[7] && scl_oe_o |-> ##[1:2] (sda_oe_o && !scl_oe_o))
      else $error("stop not started");
endmodule : scb_ctrl_chk
bind scb_ctrl scb_ctrl_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
   .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .scl_oe_o(scl_oe_o),
   .sda_oe_o(sda_oe_o), .wait_timing_o(wait_timing_o), .ack_enable_o(ack_enable_o));
`default_nettype wire

// file: test/scb_ctrl_tb.sv
// Self-checking bench for the bus control block
`timescale 1ns/10ps
`default_nettype none
module scb_ctrl_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic we = 1'b0;
   logic re = 1'b0;
   logic re_q = 1'b0;
   logic byte_done = 1'b0;
   logic addr_match = 1'b0;
   logic ext_code = 1'b0;
   logic ack_seen = 1'b0;
   logic [7:0] rdata;
   logic scl_oe, sda_oe, scl_line, sda_line, wt, ack_en, irq;
   logic [15:0] exp_q[$];
   int fails = 0;
   int tests_run = 0;
   always #5 clk = ~clk;
   // Short start hold and stop setup keep the run brief
   scb_ctrl #(.START_HOLD(4), .STOP_SETUP(4)) dut (.core_clk_i(clk), .sys_rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
      .reg_rdata_o(rdata), .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line),
      .sda_o(), .sda_oe_o(sda_oe), .addr_match_i(addr_match), .ext_code_i(ext_code),
      .ack_seen_i(ack_seen), .byte_done_i(byte_done), .wait_timing_o(wt),
      .ack_enable_o(ack_en), .irq_o(irq));
   scb_bus_model far (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl_line), .sda_o(sda_line));
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   task automatic wc(input logic [7:0] d);
      wr(scb_pkg::CTRL_ADDR, d);
   endtask : wc
   // Expected value goes on the queue with its mask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      exp_q.push_back({m, e});
      @(posedge clk);
      re <= 1'b0;
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wait_hold();
      for (int i = 0; i < 60 && scl_oe !== 1'b1; i++)
         @(posedge clk);
      chk(8'h01, {7'h0, scl_oe});
   endtask : wait_hold
   always @(posedge clk)
   begin
      re_q <= re;
      if (re_q)
      begin
         chk(exp_q[0][7:0], rdata & exp_q[0][15:8]);
         exp_q.pop_front();
      end
   end
   initial
   begin
      cyc(20000);
      fails++;
      summarize();
   end
   initial
   begin
      logic [7:0] cfg;
      logic [15:0] ua;
      cfg = 8'($urandom(32'h1d15));
      cyc(8);
      rst <= 1'b0;
      rd(scb_pkg::CTRL_ADDR, 8'h00, 8'hff);
      rd(scb_pkg::FLAG_ADDR, 8'h00, 8'hff);
      ua = 16'hffb0 | 16'($urandom_range(0, 15));
      wr(ua, 8'($urandom));
      rd(ua, 8'h00, 8'hff);
      wr(scb_pkg::FLAG_ADDR, 8'h02);
      wc(8'h40);
      rd(scb_pkg::FLAG_ADDR, 8'h02, 8'hff);
      wc(8'h4c);
      rd(scb_pkg::CTRL_ADDR, 8'h40, 8'hff);
      wc(8'h00);
      wr(scb_pkg::FLAG_ADDR, 8'h00);
      wc(8'h40);
      rd(scb_pkg::FLAG_ADDR, 8'h40, 8'hff);
      wc(8'h00);
      // Another master takes the bus; start event raises the interrupt
      wr(scb_pkg::FLAG_ADDR, 8'h02);
      wr(scb_pkg::IRQ_MASK_ADDR, 8'h02);
      wc(8'h40);
      far.start_cond();
      cyc(6);
      rd(scb_pkg::FLAG_ADDR, 8'h42, 8'hff);
      rd(scb_pkg::STAT_ADDR, 8'h04, 8'h04);
      chk(8'h01, {7'h0, irq});
      wr(scb_pkg::IRQ_ST_ADDR, 8'h02);
      cyc(2);
      chk(8'h00, {7'h0, irq});
      // Start with reservation off while busy is refused
      wr(scb_pkg::FLAG_ADDR, 8'h03);
      wc(8'h42);
      rd(scb_pkg::FLAG_ADDR, 8'hc3, 8'hff);
      chk(8'h00, {7'h0, sda_oe});
      far.stop_cond();
      cyc(6);
      rd(scb_pkg::FLAG_ADDR, 8'h03, 8'h43);
      wc(8'h00);
      // Own start with ninth-clock wait, random stop-irq and ack settings
      cfg = (cfg & 8'h14) | 8'h08;
      wr(scb_pkg::FLAG_ADDR, 8'h02);
      wc(8'h42 | cfg);
      rd(scb_pkg::CTRL_ADDR, 8'h40 | cfg, 8'hfc);
      wait_hold();
      // Byte-engine events land in the transfer status
      {addr_match, ext_code, ack_seen} <= 3'h7;
      cyc(1);
      {addr_match, ext_code, ack_seen} <= 3'h0;
      wc(8'h40 | cfg);
      cyc(1);
      chk(8'h01, {7'h0, scl_oe});
      rd(scb_pkg::STAT_ADDR, 8'hf8, 8'hf8);
      wc(8'hc0 | cfg);
      cyc(2);
      chk(8'h00, {6'h0, scl_oe, sda_oe});
      rd(scb_pkg::STAT_ADDR, 8'h80, 8'h90);
      rd(scb_pkg::CTRL_ADDR, 8'h40 | cfg, 8'hfc);
      byte_done <= 1'b1;
      cyc(1);
      byte_done <= 1'b0;
      wait_hold();
      wc(8'h41 | cfg);
      for (int i = 0; i < 60 && sda_oe !== 1'b1; i++)
         @(posedge clk);
      chk(8'h01, {7'h0, sda_oe});
      for (int i = 0; i < 60 && sda_oe !== 1'b0; i++)
         @(posedge clk);
      cyc(6);
      rd(scb_pkg::CTRL_ADDR, 8'h40 | cfg, 8'hfd);
      rd(scb_pkg::FLAG_ADDR, 8'h02, 8'h42);
      // Exit in mid-transfer
      wc(8'h42 | cfg);
      wait_hold();
      wc(8'h60 | cfg);
      rd(scb_pkg::CTRL_ADDR, 8'h40 | cfg, 8'hff);
      rd(scb_pkg::STAT_ADDR, 8'h00, 8'hfc);
      wc(8'h00);
      // Enabling against a low data line counts as a start
      far.hold_data_low(1'b1);
      cyc(4);
      wc(8'h40);
      cyc(6);
      rd(scb_pkg::STAT_ADDR, 8'h04, 8'h04);
      wc(8'h60);
      far.hold_data_low(1'b0);
      wc(8'h00);
      rd(scb_pkg::STAT_ADDR, 8'h00, 8'hff);
      cyc(2);
      summarize();
   end
endmodule : scb_ctrl_tb
`default_nettype wire
